// ---- spi_baud_gen.sv ----
`timescale 1ns/10ps
module spi_baud_gen (
  input wire logic clk_sys,
  input wire logic sys_rst,
  spi_tick_if.gen tk
);
  // Whole state of the generator
  typedef struct packed {
    logic [7:0] cnt; // Cycle within the current period
    logic [spi_pkg::BAUD_W-1:0] div; // Divider code held for the frame
  } gen_t;

  gen_t r_r;
  gen_t r_nxt;
  logic [7:0] period; // Serial clock period in clock cycles
  logic [7:0] half; // Short portion, rounded down for odd periods

  // Small codes all divide by four, larger ones by code plus one
  assign period = (r_r.div < spi_pkg::DIV_FLOOR_CODE) ? spi_pkg::DIV_FLOOR_PERIOD :
                  8'({1'b0, r_r.div} + 8'h01);
  // Odd periods give the first phase the shorter half
  assign half = period >> 1;
  assign tk.mid = tk.run && (r_r.cnt == 8'(half - 8'h01));
  assign tk.fin = tk.run && (r_r.cnt == 8'(period - 8'h01));

  // Counter restarts on every frame so the first half period is exact
  always_comb
  begin
    r_nxt = r_r;
    if (!tk.run)
    begin
      r_nxt.cnt = 8'h00;
      r_nxt.div = tk.div; // Divider only changes between frames
    end
    else if (tk.fin)
    begin
      r_nxt.cnt = 8'h00;
    end
    else
    begin
      r_nxt.cnt = 8'(r_r.cnt + 8'h01);
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      r_r <= '0;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  property p_div_four;
    @(posedge clk_sys) disable iff (sys_rst || !tk.run)
    (tk.fin && r_r.div < spi_pkg::DIV_FLOOR_CODE) |=> (!tk.fin)[*3] ##1 tk.fin;
  endproperty
  a_div_four: assert property (p_div_four) else $error("small code period is not four cycles");
  property p_period_match;
    @(posedge clk_sys) disable iff (sys_rst)
    tk.fin |-> (r_r.cnt == 8'(period - 8'h01)) && $past(tk.run);
  endproperty
  a_period_match: assert property (p_period_match) else $error("period end not at divisor");
  property p_even_range;
    @(posedge clk_sys) disable iff (sys_rst)
    (tk.fin && (!period[0] || r_r.div < spi_pkg::DIV_FLOOR_CODE))
      |-> (period >= spi_pkg::PERIOD_MIN_EVEN) && (period <= spi_pkg::PERIOD_MAX_EVEN);
  endproperty
  a_even_range: assert property (p_even_range) else $error("even period out of range");
  property p_odd_range;
    @(posedge clk_sys) disable iff (sys_rst)
    (tk.fin && period[0] && r_r.div > spi_pkg::DIV_FLOOR_CODE)
      |-> (period >= spi_pkg::PERIOD_MIN_ODD) && (period <= spi_pkg::PERIOD_MAX_ODD);
  endproperty
  a_odd_range: assert property (p_odd_range) else $error("odd period out of range");
  property p_uneven_halves;
    @(posedge clk_sys) disable iff (sys_rst)
    tk.mid |-> (8'(period - 8'((r_r.cnt + 8'h01) << 1)) == {7'h00, period[0]});
  endproperty
  a_uneven_halves: assert property (p_uneven_halves) else $error("phase halves wrong");
endmodule : spi_baud_gen

// ---- spi_master_clock_framing.sv ----
`timescale 1ns/10ps
module spi_master_clock_framing (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic SERIAL_CLOCK_OUT,
  output logic SERIAL_CLOCK_OE,
  output logic MASTER_OUT_LINE,
  output logic MASTER_OUT_OE,
  input wire logic MASTER_IN_LINE,
  output logic SLAVE_SELECT_N,
  output logic SLAVE_SELECT_OE
);
  // Whole state of the core
  typedef struct packed {
    logic in_meta; // First synchroniser stage
    logic in_sync; // Second synchroniser stage
    logic ctl_master; // Role select
    logic ctl_phase; // Clock phase select
    logic cfg_pol; // Clock polarity
    logic [spi_pkg::BAUD_W-1:0] baud; // Divider code
    logic [spi_pkg::WORD_W-1:0] tx_buf; // Word waiting to be sent
    logic tx_full; // tx_buf holds an unsent word
    logic [spi_pkg::WORD_W-1:0] rx_data; // Last word received
    logic rx_full; // rx_data not yet read
    logic [spi_pkg::WORD_W-1:0] tx_sh; // Outgoing shift register
    logic [spi_pkg::WORD_W-1:0] rx_sh; // Incoming shift register
    logic [3:0] bits; // Bits still to be sampled
    logic first; // No leading edge seen yet in this word
    logic last; // Last bit sampled, waiting for trailing edge
    logic clk_act; // Serial clock away from its idle level
    logic sclk; // Registered serial clock pin level
    logic sel_n; // Registered select, active low
    logic mo; // Registered outgoing data bit
    spi_pkg::frame_st_t st; // Framing sequencer
    logic dph_wr; // Write data phase pending
    logic [7:0] dph_addr; // Address of the pending write
    logic [31:0] rdata; // Read data for the data phase
  } core_t;

  core_t r_r;
  core_t r_nxt;
  logic bus_acc; // Address phase taken this cycle
  logic sample; // Incoming bit is captured this cycle
  logic finish; // Word completes this cycle

  spi_tick_if tk ();

  // Divider and half-period tick source
  spi_baud_gen u_gen (
    .clk_sys (CLK_SYS),
    .sys_rst (SYS_RST),
    .tk (tk)
  );

  assign tk.run = (r_r.st != spi_pkg::ST_IDLE);
  assign tk.div = r_r.baud;
  assign bus_acc = HSEL && HREADY && HTRANS[1];

  // Zero wait states, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = r_r.rdata;
  assign SERIAL_CLOCK_OUT = r_r.sclk;
  assign MASTER_OUT_LINE = r_r.mo;
  assign SLAVE_SELECT_N = r_r.sel_n;
  // Pins are driven only in the master role
  assign SERIAL_CLOCK_OE = r_r.ctl_master;
  assign MASTER_OUT_OE = r_r.ctl_master;
  assign SLAVE_SELECT_OE = r_r.ctl_master;

  // Next state: bus slave, sequencer and shifters in one pass.
  // Order matters: hardware clears come before software sets, and
  // software clears before hardware sets, so a set always wins.
  always_comb
  begin
    r_nxt = r_r;
    sample = 1'b0;
    finish = 1'b0;
    // Pin input goes through two flops before anything reads it
    r_nxt.in_meta = MASTER_IN_LINE;
    r_nxt.in_sync = r_r.in_meta;
    // Address phase capture
    r_nxt.dph_wr = bus_acc && HWRITE;
    r_nxt.dph_addr = HADDR[7:0];
    if (bus_acc && !HWRITE)
    begin
      r_nxt.rdata = 32'h0000_0000; // Unmapped offsets read as zero
      case (HADDR[7:0])
        spi_pkg::ADDR_CTRL:
        begin
          r_nxt.rdata[spi_pkg::CTL_MASTER_BIT] = r_r.ctl_master;
          r_nxt.rdata[spi_pkg::CTL_PHASE_BIT] = r_r.ctl_phase;
        end
        spi_pkg::ADDR_CFG:
        begin
          r_nxt.rdata[spi_pkg::CFG_POL_BIT] = r_r.cfg_pol;
        end
        spi_pkg::ADDR_BAUD:
        begin
          r_nxt.rdata[spi_pkg::BAUD_W-1:0] = r_r.baud;
        end
        spi_pkg::ADDR_TX:
        begin
          r_nxt.rdata[spi_pkg::WORD_W-1:0] = r_r.tx_buf;
        end
        spi_pkg::ADDR_RX:
        begin
          r_nxt.rdata[spi_pkg::WORD_W-1:0] = r_r.rx_data;
          r_nxt.rx_full = 1'b0; // Reading consumes the word
        end
        spi_pkg::ADDR_STAT:
        begin
          r_nxt.rdata[spi_pkg::STAT_RX_FULL_BIT] = r_r.rx_full;
          r_nxt.rdata[spi_pkg::STAT_TX_FULL_BIT] = r_r.tx_full;
          r_nxt.rdata[spi_pkg::STAT_BUSY_BIT] = (r_r.st != spi_pkg::ST_IDLE);
        end
        default:
        begin
          r_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
    // Framing sequencer; leading edges fall on fin, trailing on mid
    case (r_r.st)
      spi_pkg::ST_IDLE:
      begin
        if (r_r.ctl_master && r_r.tx_full)
        begin
          r_nxt.tx_sh = r_r.tx_buf;
          r_nxt.mo = r_r.tx_buf[spi_pkg::WORD_W-1];
          r_nxt.tx_full = 1'b0;
          r_nxt.bits = spi_pkg::WORD_BITS;
          r_nxt.first = 1'b1;
          r_nxt.sel_n = 1'b0;
          r_nxt.st = spi_pkg::ST_SETUP;
        end
      end
      spi_pkg::ST_SETUP:
      begin
        // Select and first bit lead the first edge by a whole period
        if (tk.mid)
        begin
          r_nxt.st = spi_pkg::ST_SHIFT;
        end
      end
      spi_pkg::ST_SHIFT:
      begin
        if (tk.fin)
        begin
          r_nxt.clk_act = 1'b1;
          r_nxt.first = 1'b0;
          if (r_r.ctl_phase)
          begin
            sample = 1'b1;
            r_nxt.last = (r_r.bits == 4'h1);
          end
          else if (!r_r.first)
          begin
            // Next bit goes out just after the leading edge
            r_nxt.tx_sh = {r_r.tx_sh[spi_pkg::WORD_W-2:0], 1'b0};
            r_nxt.mo = r_r.tx_sh[spi_pkg::WORD_W-2];
          end
        end
        else if (tk.mid)
        begin
          r_nxt.clk_act = 1'b0;
          if (!r_r.ctl_phase)
          begin
            sample = 1'b1;
            if (r_r.bits == 4'h1)
            begin
              r_nxt.st = spi_pkg::ST_DONE;
            end
          end
          else if (r_r.last)
          begin
            finish = 1'b1;
          end
          else
          begin
            // Phase 1 sets the bit half a period before its edge
            r_nxt.tx_sh = {r_r.tx_sh[spi_pkg::WORD_W-2:0], 1'b0};
            r_nxt.mo = r_r.tx_sh[spi_pkg::WORD_W-2];
          end
        end
      end
      spi_pkg::ST_DONE:
      begin
        // Half a period after the last receiving edge
        if (tk.fin)
        begin
          finish = 1'b1;
        end
      end
      default:
      begin
        r_nxt.st = spi_pkg::ST_IDLE;
        r_nxt.sel_n = 1'b1;
        r_nxt.clk_act = 1'b0;
      end
    endcase
    if (sample)
    begin
      r_nxt.rx_sh = {r_r.rx_sh[spi_pkg::WORD_W-2:0], r_r.in_sync};
      r_nxt.bits = 4'(r_r.bits - 4'h1);
    end
    if (finish)
    begin
      r_nxt.rx_data = r_nxt.rx_sh;
      r_nxt.rx_full = 1'b1; // Set wins over a read in the same cycle
      r_nxt.last = 1'b0;
      if (r_r.tx_full)
      begin
        // Back-to-back word: select stays low
        r_nxt.tx_sh = r_r.tx_buf;
        r_nxt.mo = r_r.tx_buf[spi_pkg::WORD_W-1];
        r_nxt.tx_full = 1'b0;
        r_nxt.bits = spi_pkg::WORD_BITS;
        r_nxt.first = 1'b1;
        r_nxt.st = r_r.ctl_phase ? spi_pkg::ST_SHIFT : spi_pkg::ST_SETUP;
      end
      else
      begin
        r_nxt.sel_n = 1'b1;
        r_nxt.st = spi_pkg::ST_IDLE;
      end
    end
    // Leaving the master role aborts the word at once; the partial
    // word is dropped rather than completed on a dead bus
    if (!r_r.ctl_master)
    begin
      r_nxt.st = spi_pkg::ST_IDLE;
      r_nxt.sel_n = 1'b1;
      r_nxt.clk_act = 1'b0;
      r_nxt.last = 1'b0;
      r_nxt.mo = r_r.mo; // Data holds: no clock edge goes with the abort
    end
    // Data phase of a write; a word written now beats the hardware load
    if (r_r.dph_wr)
    begin
      case (r_r.dph_addr)
        spi_pkg::ADDR_CTRL:
        begin
          r_nxt.ctl_master = HWDATA[spi_pkg::CTL_MASTER_BIT];
          r_nxt.ctl_phase = HWDATA[spi_pkg::CTL_PHASE_BIT];
        end
        spi_pkg::ADDR_CFG:
        begin
          r_nxt.cfg_pol = HWDATA[spi_pkg::CFG_POL_BIT];
        end
        spi_pkg::ADDR_BAUD:
        begin
          r_nxt.baud = HWDATA[spi_pkg::BAUD_W-1:0];
        end
        spi_pkg::ADDR_TX:
        begin
          r_nxt.tx_buf = HWDATA[spi_pkg::WORD_W-1:0];
          r_nxt.tx_full = 1'b1;
        end
        default:
        begin
          r_nxt.dph_wr = r_nxt.dph_wr; // Read-only or unmapped: ignored
        end
      endcase
    end
    // Pin level is polarity folded onto the active flag
    r_nxt.sclk = r_nxt.cfg_pol ^ r_nxt.clk_act;
  end

  // State register
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      r_r <= '0;
      r_r.ctl_master <= spi_pkg::CTL_MASTER_RST;
      r_r.ctl_phase <= spi_pkg::CTL_PHASE_RST;
      r_r.cfg_pol <= spi_pkg::CFG_POL_RST;
      r_r.baud <= spi_pkg::BAUD_RST;
      r_r.sel_n <= 1'b1;
      r_r.st <= spi_pkg::ST_IDLE;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  property p_idle_level;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (r_r.st == spi_pkg::ST_IDLE) ##1 (r_r.st == spi_pkg::ST_IDLE) |-> (SERIAL_CLOCK_OUT == r_r.cfg_pol);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock not at idle level");
  property p_slave_quiet;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    !r_r.ctl_master ##1 !r_r.ctl_master |-> SLAVE_SELECT_N && !SLAVE_SELECT_OE && !r_r.clk_act;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("frame activity outside master role");
  property p_sample_edge;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    sample |-> (r_r.ctl_phase ? tk.fin : tk.mid) && (r_r.st == spi_pkg::ST_SHIFT);
  endproperty
  a_sample_edge: assert property (p_sample_edge) else $error("sample on wrong edge");
  property p_ph0_drive;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    ($changed(r_r.mo) && !r_r.ctl_phase && $past(r_r.st) == spi_pkg::ST_SHIFT) |-> $past(tk.fin) && r_r.clk_act;
  endproperty
  a_ph0_drive: assert property (p_ph0_drive) else $error("phase 0 data moved off leading edge");
  property p_ph1_drive;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    ($changed(r_r.mo) && r_r.ctl_phase && $past(r_r.st) == spi_pkg::ST_SHIFT) |-> $past(tk.mid) && !r_r.clk_act;
  endproperty
  a_ph1_drive: assert property (p_ph1_drive) else $error("phase 1 data moved off trailing edge");
  property p_sel_covers_clock;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    r_r.clk_act |-> !SLAVE_SELECT_N;
  endproperty
  a_sel_covers_clock: assert property (p_sel_covers_clock) else $error("clock active without select");
  property p_sel_lead;
    @(posedge CLK_SYS) disable iff (SYS_RST || !r_r.ctl_master)
    $fell(SLAVE_SELECT_N) |-> !r_r.clk_act [*2];
  endproperty
  a_sel_lead: assert property (p_sel_lead) else $error("select did not lead first edge");
endmodule : spi_master_clock_framing

// ---- spi_master_clock_framing_bench.sv ----
`timescale 1ns/10ps
module spi_master_clock_framing_bench;
  logic CLK_SYS = 1'h0;
  logic SYS_RST = 1'h1;
  logic HSEL = 1'h0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'h0;
  logic [2:0] HSIZE = 3'h2; // Word transfers only
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, SERIAL_CLOCK_OUT, SERIAL_CLOCK_OE, MASTER_OUT_LINE, MASTER_OUT_OE;
  logic MASTER_IN_LINE, SLAVE_SELECT_N, SLAVE_SELECT_OE;
  logic cur_pol = 1'h0; // Mode the monitor and slave follow
  logic cur_ph = 1'h0;
  logic [7:0] reply = 8'h00; // Slave answer byte
  logic [7:0] got;
  logic [7:0] n_words;
  logic sclk_q = 1'h0;
  logic ss_q = 1'h1;
  int fail_count = 0;
  int n_compared = 0;
  int now = 0;
  int n_lead, n_rise, t_fall, t_rise, t_lead, t_lead1, t_samp, per_lo, per_hi, act_lo, act_hi;
  logic [6:0] small_codes [7] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h7E, 7'h7F};
  always #4 CLK_SYS = ~CLK_SYS;
  spi_master_clock_framing spi_master_clock_framing_inst (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SERIAL_CLOCK_OUT(SERIAL_CLOCK_OUT),
    .SERIAL_CLOCK_OE(SERIAL_CLOCK_OE), .MASTER_OUT_LINE(MASTER_OUT_LINE), .MASTER_OUT_OE(MASTER_OUT_OE),
    .MASTER_IN_LINE(MASTER_IN_LINE), .SLAVE_SELECT_N(SLAVE_SELECT_N), .SLAVE_SELECT_OE(SLAVE_SELECT_OE));
  spi_slave_model spi_slave_model_inst (.clk(CLK_SYS), .sclk(SERIAL_CLOCK_OUT), .mosi(MASTER_OUT_LINE),
    .ss_n(SLAVE_SELECT_N), .cpol(cur_pol), .cpha(cur_ph), .reply(reply), .miso(MASTER_IN_LINE), .got(got),
    .n_words(n_words));
  // Expected serial period in system clocks
  function automatic int exp_n(input logic [6:0] code);
    return (code < 7'h03) ? 4 : int'(code) + 1;
  endfunction : exp_n
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  // Edge monitor and hang guard; a run needs well under 40000 cycles
  always @(posedge CLK_SYS)
  begin
    now++;
    if (SLAVE_SELECT_N === 1'h0 && ss_q === 1'h1)
      t_fall = now;
    if (SLAVE_SELECT_N === 1'h1 && ss_q === 1'h0)
    begin
      t_rise = now;
      n_rise++;
    end
    if (SERIAL_CLOCK_OUT !== cur_pol && sclk_q === cur_pol)
    begin
      if (n_lead == 0)
        t_lead1 = now;
      else
      begin
        per_lo = (now - t_lead < per_lo) ? now - t_lead : per_lo;
        per_hi = (now - t_lead > per_hi) ? now - t_lead : per_hi;
      end
      t_lead = now;
      n_lead++;
      if (cur_ph)
        t_samp = now;
    end
    if (SERIAL_CLOCK_OUT === cur_pol && sclk_q !== cur_pol)
    begin
      act_lo = (now - t_lead < act_lo) ? now - t_lead : act_lo;
      act_hi = (now - t_lead > act_hi) ? now - t_lead : act_hi;
      if (!cur_ph)
        t_samp = now;
    end
    sclk_q = SERIAL_CLOCK_OUT;
    ss_q = SLAVE_SELECT_N;
    // Hang guard last, so nothing runs after the closing report
    if (now > 40000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  // Single write: address phase until ready, then data phase until ready
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'h1;
    HADDR <= {24'h0, a};
    HTRANS <= 2'h2;
    HWRITE <= 1'h1;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'h1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'h1);
  endtask : bus_wr
  // Single read: data taken at the edge that ends the data phase
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    HSEL <= 1'h1;
    HADDR <= {24'h0, a};
    HTRANS <= 2'h2;
    HWRITE <= 1'h0;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'h1);
    HTRANS <= 2'h0;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'h1);
    d = HRDATA;
    chk("bus response", 32'h0, 32'(HRESP));
  endtask : bus_rd
  // One frame of one or two words in the given mode, then timing and data checks
  task automatic frame(input logic pol, input logic ph, input logic [6:0] code, input int words);
    logic [7:0] b;
    logic [31:0] st;
    int n;
    int h;
    int k;
    logic [7:0] w0;
    n = exp_n(code);
    h = n / 2;
    b = 8'($urandom);
    cur_pol = pol;
    cur_ph = ph;
    reply <= 8'($urandom);
    bus_wr(spi_pkg::ADDR_CTRL, (32'(ph) << spi_pkg::CTL_PHASE_BIT) | 32'h4);
    bus_wr(spi_pkg::ADDR_CFG, 32'(pol) << spi_pkg::CFG_POL_BIT);
    bus_wr(spi_pkg::ADDR_BAUD, 32'(code));
    @(posedge CLK_SYS);
    chk("clock idle level", 32'(pol), 32'(SERIAL_CLOCK_OUT));
    chk("clock enable", 32'h1, 32'(SERIAL_CLOCK_OE & MASTER_OUT_OE & SLAVE_SELECT_OE));
    n_lead = 0;
    n_rise = 0;
    per_lo = 9999;
    per_hi = 0;
    act_lo = 9999;
    act_hi = 0;
    w0 = n_words;
    repeat (words) bus_wr(spi_pkg::ADDR_TX, 32'(b));
    k = 0;
    st = 32'h6;
    while ((st & 32'h6) !== 32'h0 && k < 5000)
    begin
      bus_rd(spi_pkg::ADDR_STAT, st);
      k++;
    end
    repeat (2) @(posedge CLK_SYS);
    chk("frame finished", 32'h1, 32'(k < 5000));
    chk("word ready flag", 32'h1, st & 32'h1);
    chk("slave words", 32'(words), 32'(n_words - w0));
    chk("leading edges", 32'(8 * words), 32'(n_lead));
    chk("select releases", 32'h1, 32'(n_rise));
    chk("clock back at idle", 32'(pol), 32'(SERIAL_CLOCK_OUT));
    if (words == 1)
    begin
      chk("shortest period", 32'(n), 32'(per_lo));
      chk("longest period", 32'(n), 32'(per_hi));
      chk("active phase min", 32'(h), 32'(act_lo));
      chk("active phase max", 32'(h), 32'(act_hi));
      // Select leads the first edge by a whole period, above the half-period minimum
      chk("select lead", 32'(n), 32'(t_lead1 - t_fall));
      k = ph ? h : n - h;
      chk("select lag", 32'h1, 32'(t_rise - t_samp >= k && t_rise - t_samp <= k + 1));
    end
    // Data compared only where the serial rate stays within receive limits
    if (n >= 13)
    begin
      chk("slave word", 32'(b), 32'(got));
      bus_rd(spi_pkg::ADDR_RX, st);
      chk("received word", 32'(reply), st & 32'hFF);
      bus_rd(spi_pkg::ADDR_STAT, st);
      chk("word flag cleared", 32'h0, st & 32'h1);
    end
    $display("frame pol %0d phase %0d code %0d words %0d done", pol, ph, code, words);
  endtask : frame
  initial
  begin
    logic [31:0] d;
    logic [7:0] regs [6];
    regs = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h3C};
    void'($urandom(32'h38791874));
    repeat (2) @(posedge CLK_SYS);
    SYS_RST <= 1'h0;
    chk("select idle", 32'h1, 32'(SLAVE_SELECT_N));
    chk("enables off", 32'h0, 32'(SERIAL_CLOCK_OE | MASTER_OUT_OE | SLAVE_SELECT_OE));
    bus_wr(8'h3C, 32'hFFFFFFFF);
    bus_wr(spi_pkg::ADDR_STAT, 32'hFFFFFFFF);
    foreach (regs[i])
    begin
      bus_rd(regs[i], d);
      chk("register reset or ignored write", 32'h0, d);
    end
    $display("register reset test done");
    // Dropping the master role mid-word must abort it and free the select
    bus_wr(spi_pkg::ADDR_CTRL, 32'h1 << spi_pkg::CTL_MASTER_BIT);
    bus_wr(spi_pkg::ADDR_TX, 32'(8'($urandom)));
    repeat (6) @(posedge CLK_SYS);
    chk("select during word", 32'h0, 32'(SLAVE_SELECT_N));
    bus_wr(spi_pkg::ADDR_CTRL, 32'h0);
    @(posedge CLK_SYS);
    bus_rd(spi_pkg::ADDR_STAT, d);
    chk("abort leaves idle", 32'h0, d & 32'h6);
    chk("abort releases select", 32'h1, 32'(SLAVE_SELECT_N));
    chk("abort drops enables", 32'h0, 32'(SERIAL_CLOCK_OE | MASTER_OUT_OE | SLAVE_SELECT_OE));
    $display("master abort test done");
    for (int m = 0; m < 4; m++)
      frame(m[0], m[1], 7'(12 + $urandom % 116), 1);
    foreach (small_codes[i])
      frame(i[0], i[1], small_codes[i], 1);
    frame(1'h0, 1'h0, 7'(12 + $urandom % 116), 2);
    frame(1'h1, 1'h1, 7'(12 + $urandom % 116), 2);
    report_and_stop();
  end
endmodule : spi_master_clock_framing_bench

// ---- spi_pkg.sv ----
package spi_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] ADDR_CTRL = 8'h00; // operation_control_reg
  localparam logic [7:0] ADDR_CFG = 8'h04; // character_config_reg
  localparam logic [7:0] ADDR_BAUD = 8'h08; // baud_divider_field
  localparam logic [7:0] ADDR_TX = 8'h0C; // Transmit word, write starts a frame in the master role
  localparam logic [7:0] ADDR_RX = 8'h10; // Received word, read clears rx_full
  localparam logic [7:0] ADDR_STAT = 8'h14; // Status flags
  // Field positions
  localparam int CTL_MASTER_BIT = 2; // Role select, 1 = bus master
  localparam int CTL_PHASE_BIT = 3; // Clock phase select
  localparam int CFG_POL_BIT = 6; // Clock polarity, idle level
  localparam int STAT_RX_FULL_BIT = 0;
  localparam int STAT_TX_FULL_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int BAUD_W = 7; // Divider field width
  localparam int WORD_W = 8; // Bits per word, MSB first
  // Reset values
  localparam logic CTL_MASTER_RST = 1'b0;
  localparam logic CTL_PHASE_RST = 1'b0;
  localparam logic CFG_POL_RST = 1'b0;
  localparam logic [BAUD_W-1:0] BAUD_RST = 7'h00;
  // Divider timing: codes below the floor code divide by four
  localparam logic [BAUD_W-1:0] DIV_FLOOR_CODE = 7'h03;
  localparam logic [7:0] DIV_FLOOR_PERIOD = 8'h04;
  localparam logic [7:0] PERIOD_MIN_EVEN = 8'h04;
  localparam logic [7:0] PERIOD_MAX_EVEN = 8'h80;
  localparam logic [7:0] PERIOD_MIN_ODD = 8'h05;
  localparam logic [7:0] PERIOD_MAX_ODD = 8'h7F;
  localparam logic [3:0] WORD_BITS = 4'h8;
  // Framing sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_DONE = 4'b1000
  } frame_st_t;
endpackage : spi_pkg

// ---- spi_slave_model.sv ----
`timescale 1ns/10ps
// Behavioural serial slave: shifts MSB first and answers every word with one reply byte
module spi_slave_model (
  input wire logic clk,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [7:0] reply,
  output logic miso,
  output logic [7:0] got,
  output logic [7:0] n_words
);
  logic sclk_q = 1'h0; // Clock level seen at the previous edge
  logic [7:0] tx_sh = 8'h00; // Reply shifter
  logic [7:0] rx_sh = 8'h00; // Receive shifter
  logic [3:0] n_bits = 4'h0; // Bits sampled in this word
  logic junk = 1'h0; // Toggles so a released line never looks stable
  logic lead;
  logic trail;
  logic samp;
  logic drv;
  assign lead = (sclk != cpol) && (sclk_q == cpol);
  assign trail = (sclk == cpol) && (sclk_q != cpol);
  // Phase 0 samples on the trailing edge, phase 1 on the leading edge
  assign samp = cpha ? lead : trail;
  assign drv = cpha ? trail : lead;
  // Deselected: a changing pattern, never the last bit
  assign miso = ss_n ? junk : tx_sh[7];
  initial
  begin
    got = 8'h00;
    n_words = 8'h00;
  end
  // Shift only after a first sample, so the first leading edge of phase 0 keeps bit 7
  always @(posedge clk)
  begin
    sclk_q <= sclk;
    junk <= ~junk;
    if (ss_n)
    begin
      tx_sh <= reply;
      n_bits <= 4'h0;
    end
    else if (samp)
    begin
      rx_sh <= {rx_sh[6:0], mosi};
      n_bits <= n_bits + 4'h1;
      if (n_bits == 4'h7)
      begin
        got <= {rx_sh[6:0], mosi};
        n_words <= n_words + 8'h01;
        n_bits <= 4'h0;
        tx_sh <= reply; // Back-to-back word starts from its first bit
      end
    end
    else if (drv && n_bits != 4'h0)
      tx_sh <= {tx_sh[6:0], 1'h0};
  end
endmodule : spi_slave_model

// ---- spi_tick_if.sv ----
`timescale 1ns/10ps
// Tick carrier between the framing core and the baud generator
interface spi_tick_if;
  logic run; // Generator counts while high, restarts from zero when low
  logic [spi_pkg::BAUD_W-1:0] div; // Divider code, latched while idle
  logic mid; // End of the short (active) portion of a period
  logic fin; // End of a whole serial clock period
  modport gen (input run, input div, output mid, output fin);
  modport core (output run, output div, input mid, input fin);
endinterface : spi_tick_if
